//--- rtl/scoc_pkg.sv
// Purpose: Shared constants for the serial channel output control block.
// Assumes: 20-bit byte addresses, 8-bit register data, two channels.
// Notes: Pin-facing logic exists for channel 0 only; channel 1 has status bits.
package scoc_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 2;

    // Register byte addresses
    localparam logic [19:0] ADDR_RX_NOISE_FILTER_ENABLE = 20'hf0070;
    localparam logic [19:0] ADDR_INPUT_ROUTE_SELECT = 20'hf0073;
    localparam logic [19:0] ADDR_CHANNEL_ENABLE_STATUS = 20'hf0120;
    localparam logic [19:0] ADDR_CHANNEL_START = 20'hf0122;
    localparam logic [19:0] ADDR_CHANNEL_STOP = 20'hf0124;
    localparam logic [19:0] ADDR_SERIAL_DATA_OUT_BUFFER = 20'hf0128;
    localparam logic [19:0] ADDR_SERIAL_CLOCK_OUT_BUFFER = 20'hf0129;
    localparam logic [19:0] ADDR_SERIAL_OUTPUT_ENABLE = 20'hf012a;
    localparam logic [19:0] ADDR_OUTPUT_LEVEL_INVERT = 20'hf0134;

    // Reset values
    localparam logic [7:0] RST_RX_NOISE_FILTER_ENABLE = 8'h00;
    localparam logic [7:0] RST_INPUT_ROUTE_SELECT = 8'h00;
    localparam logic [1:0] RST_CHANNEL_ENABLE_STATUS = 2'h0;
    localparam logic [1:0] RST_SERIAL_DATA_OUT_BUFFER = 2'h3;
    localparam logic [1:0] RST_SERIAL_CLOCK_OUT_BUFFER = 2'h3;
    localparam logic RST_SERIAL_OUTPUT_ENABLE = 1'b0;
    localparam logic RST_OUTPUT_LEVEL_INVERT = 1'b0;
    localparam logic RST_RX_LEVEL = 1'b1;

    // Field positions
    localparam int BIT_RX_FILTER_ON = 0;
    localparam int BIT_RX_TO_EXT_IRQ = 0;
    localparam int BIT_RX_TO_TIMER = 1;
    localparam int BIT_DATA_OUT_CH0 = 0;
    localparam int BIT_CLOCK_OUT_CH0 = 0;
    localparam int BIT_DATA_OUT_ENABLE = 0;
    localparam int BIT_TX_INVERT = 0;
    localparam int BUF_BITS = 2;

    // Filter: number of equal samples that make a level valid
    localparam int FILTER_STABLE_CYCLES = 2;

    // Read data mux select
    typedef enum logic [3:0] {
        SCOC_SEL_NONE = 4'h0,
        SCOC_SEL_NFEN = 4'h1,
        SCOC_SEL_ROUTE = 4'h2,
        SCOC_SEL_SE = 4'h3,
        SCOC_SEL_TRIG = 4'h4,
        SCOC_SEL_SO = 4'h5,
        SCOC_SEL_CKO = 4'h6,
        SCOC_SEL_SOE = 4'h7,
        SCOC_SEL_SOL = 4'h8
    } scoc_sel_t;

    // Address decode, used by both write and read paths
    function automatic scoc_sel_t scoc_decode(input logic [19:0] addr);
        case (addr)
            ADDR_RX_NOISE_FILTER_ENABLE: scoc_decode = SCOC_SEL_NFEN;
            ADDR_INPUT_ROUTE_SELECT: scoc_decode = SCOC_SEL_ROUTE;
            ADDR_CHANNEL_ENABLE_STATUS: scoc_decode = SCOC_SEL_SE;
            ADDR_CHANNEL_START: scoc_decode = SCOC_SEL_TRIG;
            ADDR_CHANNEL_STOP: scoc_decode = SCOC_SEL_TRIG;
            ADDR_SERIAL_DATA_OUT_BUFFER: scoc_decode = SCOC_SEL_SO;
            ADDR_SERIAL_CLOCK_OUT_BUFFER: scoc_decode = SCOC_SEL_CKO;
            ADDR_SERIAL_OUTPUT_ENABLE: scoc_decode = SCOC_SEL_SOE;
            ADDR_OUTPUT_LEVEL_INVERT: scoc_decode = SCOC_SEL_SOL;
            default: scoc_decode = SCOC_SEL_NONE;
        endcase
    endfunction
endpackage

//--- rtl/scoc_rx_if.sv
// Purpose: Carries the receive pin path between top and filter.
// Assumes: One clock domain, operating clock given as an enable.
// Notes: Top drives raw, mck_en and filter_on; filter returns level.
interface scoc_rx_if;
    logic raw;
    logic mck_en;
    logic filter_on;
    logic level;
    modport src (output raw, output mck_en, output filter_on, input level);
    modport flt (input raw, input mck_en, input filter_on, output level);
endinterface

//--- rtl/scoc_rx_filter.sv
// Purpose: Synchronises and optionally deglitches the receive pin.
// Assumes: mck_en pulses once per operating clock of the channel.
// Notes: Idle line level is high, so all stages reset to one.
module scoc_rx_filter
    import scoc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    scoc_rx_if.flt rx
);
    logic sync_a;
    logic sync_b;
    logic prev_b;
    logic level;

    // Two-stage synchroniser; sync_a feeds only sync_b
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a <= RST_RX_LEVEL;
            sync_b <= RST_RX_LEVEL;
            prev_b <= RST_RX_LEVEL;
        end else if (rx.mck_en) begin
            sync_a <= rx.raw;
            sync_b <= sync_a;
            prev_b <= sync_b;
        end
    end

    // Filter on: take a level only once two samples agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            level <= RST_RX_LEVEL;
        end else if (rx.mck_en) begin
            if (!rx.filter_on) begin
                level <= sync_b; // R18
            end else if (sync_b == prev_b) begin
                level <= sync_b; // R17
            end
        end
    end

    assign rx.level = level;
endmodule

//--- rtl/scoc_out_stage.sv
// Purpose: Registers the channel 0 data and clock pin levels.
// Assumes: Buffer bits already hold the right source per enable state.
// Notes: Inversion touches only the data pin and only when output is enabled.
module scoc_out_stage
    import scoc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic data_bit,
    input wire logic clock_bit,
    input wire logic out_enable,
    input wire logic invert,
    output logic data_pin,
    output logic clock_pin
);
    // Pins reset to the buffer reset level, idle high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_pin <= RST_SERIAL_DATA_OUT_BUFFER[BIT_DATA_OUT_CH0];
            clock_pin <= RST_SERIAL_CLOCK_OUT_BUFFER[BIT_CLOCK_OUT_CH0];
        end else begin
            data_pin <= out_enable ? (data_bit ^ invert) : data_bit; // R13 R14
            clock_pin <= clock_bit; // R5 R6
        end
    end
endmodule

//--- rtl/scoc_top.sv
// Purpose: Control and status registers around a two-channel serial unit.
// Assumes: 8-bit memory-mapped register port, one access per cycle;
//          transfer engines sit outside and report pin updates here.
// Notes: Read data appears one cycle after the read strobe.
//
// Summary of operation
// R1 - Writing 1 to a stop bit clears that channel's enable and halts it.
// R2 - A stop leaves control registers, shift register, pins and error flags alone.
// R3 - The stop trigger register always reads as zero.
// R4 - Enable status sets on start write, clears on stop write.
// R5 - While enabled, software clock-buffer writes are ignored; pin follows engine.
// R6 - While disabled, software writes the clock buffer and it drives the pin.
// R7 - With output enabled, data pin follows engine; software data writes ignored.
// R8 - With output disabled, software data buffer value drives the data pin.
// R9 - Data buffer changes by engine only while output is enabled.
// R10 - Clock buffer changes by engine only while the channel is enabled.
// R11 - Software sets both buffer bits to 1 to use pins as ports.
// R12 - Software writes buffer bit 1 as 1, bits 2 to 7 as 0.
// R13 - Inversion bit set inverts the transmit level on the pin.
// R14 - Inversion acts only while output is enabled.
// R15 - Software keeps inversion at 0 in clocked mode and while enabled.
// R16 - Software leaves the inversion register alone while enabled.
// R17 - Filter on: synchronise, then accept a level stable two cycles.
// R18 - Filter off: synchronise only.
// R19 - Software uses the filter for the UART receive pin only.
// R20 - Route bit 0 sends the receive pin to the external interrupt input.
// R21 - Route bit 1 sends the receive pin to timer channel 1 input.
// R22 - Writing 1 to a start bit sets enable and enters wait; trigger self-clears.
// R23 - All registers run on the peripheral clock and reset to documented values.
module scoc_top
    import scoc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Transfer engine side
    input wire logic mck_en,
    input wire logic eng_data_update,
    input wire logic eng_data_value,
    input wire logic eng_clock_update,
    input wire logic eng_clock_value,
    output logic [NUM_CH-1:0] chan_enabled_flag,
    output logic [NUM_CH-1:0] chan_start_pulse,
    output logic [NUM_CH-1:0] chan_halt_pulse,
    output logic rx_level,
    // Pins and routed inputs
    input wire logic uart_rx_pin,
    input wire logic ext_irq_pin,
    input wire logic timer_ch1_pin,
    output logic serial_data_out_pin,
    output logic serial_clock_pin,
    output logic ext_irq_input,
    output logic timer_ch1_input
);
    scoc_sel_t wr_sel;
    scoc_sel_t rd_sel;
    logic wr_start;
    logic wr_stop;
    logic [NUM_CH-1:0] chan_start_trigger;
    logic [NUM_CH-1:0] chan_stop_trigger;
    logic rx_filter_on_bit;
    logic rx_to_ext_irq_bit;
    logic rx_to_timer_bit;
    logic [BUF_BITS-1:0] data_out_buffer;
    logic [BUF_BITS-1:0] clock_out_buffer;
    logic data_out_enable_bit;
    logic tx_invert_bit;
    logic [DATA_W-1:0] next_rdata;

    scoc_rx_if rx_bus ();

    // Address decode for both strobes
    assign wr_sel = scoc_decode(reg_addr);
    assign rd_sel = wr_sel;
    assign wr_start = reg_wr && (reg_addr == ADDR_CHANNEL_START);
    assign wr_stop = reg_wr && (reg_addr == ADDR_CHANNEL_STOP);

    // Trigger bits exist only for the write cycle, never stored
    assign chan_start_trigger = wr_start ? reg_wdata[NUM_CH-1:0] : '0; // R22
    assign chan_stop_trigger = wr_stop ? reg_wdata[NUM_CH-1:0] : '0; // R1

    // Enable status; start and stop sit at different addresses
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chan_enabled_flag <= RST_CHANNEL_ENABLE_STATUS; // R23
        end else begin
            chan_enabled_flag <= (chan_enabled_flag | chan_start_trigger)
                & ~chan_stop_trigger; // R4 R1 R22
        end
    end

    // One-cycle notices to the engines; a stop only halts them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chan_start_pulse <= '0;
            chan_halt_pulse <= '0;
        end else begin
            chan_start_pulse <= chan_start_trigger; // R22
            chan_halt_pulse <= chan_stop_trigger; // R1
        end
    end

    // Noise filter and route selects: plain software registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_filter_on_bit <= RST_RX_NOISE_FILTER_ENABLE[BIT_RX_FILTER_ON];
            rx_to_ext_irq_bit <= RST_INPUT_ROUTE_SELECT[BIT_RX_TO_EXT_IRQ];
            rx_to_timer_bit <= RST_INPUT_ROUTE_SELECT[BIT_RX_TO_TIMER];
        end else if (reg_wr) begin
            if (wr_sel == SCOC_SEL_NFEN) begin
                rx_filter_on_bit <= reg_wdata[BIT_RX_FILTER_ON];
            end
            if (wr_sel == SCOC_SEL_ROUTE) begin
                rx_to_ext_irq_bit <= reg_wdata[BIT_RX_TO_EXT_IRQ];
                rx_to_timer_bit <= reg_wdata[BIT_RX_TO_TIMER];
            end
        end
    end

    // Output enable and inversion; neither is touched by a stop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_out_enable_bit <= RST_SERIAL_OUTPUT_ENABLE;
            tx_invert_bit <= RST_OUTPUT_LEVEL_INVERT;
        end else if (reg_wr) begin
            if (wr_sel == SCOC_SEL_SOE) begin
                data_out_enable_bit <= reg_wdata[BIT_DATA_OUT_ENABLE];
            end
            // Rewrite while enabled is a software fault, not blocked here
            if (wr_sel == SCOC_SEL_SOL) begin
                tx_invert_bit <= reg_wdata[BIT_TX_INVERT];
            end
        end
    end

    // Data buffer: engine owns bit 0 while output enabled, software otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_out_buffer <= RST_SERIAL_DATA_OUT_BUFFER; // R23
        end else if (data_out_enable_bit) begin
            if (eng_data_update) begin
                data_out_buffer[BIT_DATA_OUT_CH0] <= eng_data_value; // R7 R9
            end
        end else if (reg_wr && wr_sel == SCOC_SEL_SO) begin
            data_out_buffer <= reg_wdata[BUF_BITS-1:0]; // R8 R9
        end
    end

    // Clock buffer: engine owns bit 0 while channel 0 enabled
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clock_out_buffer <= RST_SERIAL_CLOCK_OUT_BUFFER; // R23
        end else if (chan_enabled_flag[0]) begin
            if (eng_clock_update) begin
                clock_out_buffer[BIT_CLOCK_OUT_CH0] <= eng_clock_value; // R5 R10
            end
        end else if (reg_wr && wr_sel == SCOC_SEL_CKO) begin
            clock_out_buffer <= reg_wdata[BUF_BITS-1:0]; // R6 R10
        end
    end

    // Pin drivers; buffers are untouched by stop so pins hold their level
    scoc_out_stage u_out (
        .sys_clk(sys_clk),
        .rst(rst),
        .data_bit(data_out_buffer[BIT_DATA_OUT_CH0]),
        .clock_bit(clock_out_buffer[BIT_CLOCK_OUT_CH0]),
        .out_enable(data_out_enable_bit),
        .invert(tx_invert_bit),
        .data_pin(serial_data_out_pin), // R2
        .clock_pin(serial_clock_pin)
    );

    // Receive path through the filter
    assign rx_bus.raw = uart_rx_pin;
    assign rx_bus.mck_en = mck_en;
    assign rx_bus.filter_on = rx_filter_on_bit;

    scoc_rx_filter u_rx (
        .sys_clk(sys_clk),
        .rst(rst),
        .rx(rx_bus)
    );

    // Registered copies keep every output straight from a flip-flop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_level <= RST_RX_LEVEL;
            ext_irq_input <= 1'b0;
            timer_ch1_input <= 1'b0;
        end else begin
            rx_level <= rx_bus.level;
            // Routed copy uses the synchronised line, glitch-safe for edges
            ext_irq_input <= rx_to_ext_irq_bit ? rx_bus.level : ext_irq_pin; // R20
            timer_ch1_input <= rx_to_timer_bit ? rx_bus.level : timer_ch1_pin; // R21
        end
    end

    // Read mux; unmapped and trigger addresses read zero
    always_comb begin
        next_rdata = '0;
        case (rd_sel)
            SCOC_SEL_NFEN: next_rdata[BIT_RX_FILTER_ON] = rx_filter_on_bit;
            SCOC_SEL_ROUTE: begin
                next_rdata[BIT_RX_TO_EXT_IRQ] = rx_to_ext_irq_bit;
                next_rdata[BIT_RX_TO_TIMER] = rx_to_timer_bit;
            end
            SCOC_SEL_SE: next_rdata[NUM_CH-1:0] = chan_enabled_flag;
            SCOC_SEL_TRIG: next_rdata = '0; // R3
            SCOC_SEL_SO: next_rdata[BUF_BITS-1:0] = data_out_buffer;
            SCOC_SEL_CKO: next_rdata[BUF_BITS-1:0] = clock_out_buffer;
            SCOC_SEL_SOE: next_rdata[BIT_DATA_OUT_ENABLE] = data_out_enable_bit;
            SCOC_SEL_SOL: next_rdata[BIT_TX_INVERT] = tx_invert_bit;
            default: next_rdata = '0;
        endcase
    end

    // Read data registered; holds its last value between reads
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

//--- test/scoc_peer.sv
// Purpose: Far-side serial peer that drives the receive line.
// Assumes: Called just after a rising clock edge.
// Notes: The line idles high between bursts, as a UART line does.
module scoc_peer (
    input wire logic sys_clk,
    output logic uart_rx_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial uart_rx_pin = 1'b1;

    // Hold a level for n edges, then return to the idle mark level
    task automatic send_level(input logic v, input int n);
        uart_rx_pin = v;
        repeat (n) @(posedge sys_clk);
        #1 uart_rx_pin = 1'b1;
    endtask
endmodule

//--- test/scoc_top_chk.sv
// Purpose: Port-level checks on the serial channel output control block.
// Assumes: Pins follow a buffer update two edges later.
// Notes: Control bits are shadowed from writes, since the checker sees ports only.
module scoc_top_chk
    import scoc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic mck_en,
    input wire logic eng_data_update,
    input wire logic eng_data_value,
    input wire logic eng_clock_update,
    input wire logic [NUM_CH-1:0] chan_enabled_flag,
    input wire logic [NUM_CH-1:0] chan_start_pulse,
    input wire logic [NUM_CH-1:0] chan_halt_pulse,
    input wire logic rx_level,
    input wire logic uart_rx_pin,
    input wire logic ext_irq_pin,
    input wire logic timer_ch1_pin,
    input wire logic serial_data_out_pin,
    input wire logic serial_clock_pin,
    input wire logic ext_irq_input,
    input wire logic timer_ch1_input
);
    logic soe_sh, inv_sh, nf_sh;
    logic [1:0] route_sh;
    logic [2:0] run;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Shadows update on the same edge as the design registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            soe_sh <= 1'b0;
            inv_sh <= 1'b0;
            nf_sh <= 1'b0;
            route_sh <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_SERIAL_OUTPUT_ENABLE) soe_sh <= reg_wdata[0];
            if (reg_addr == ADDR_OUTPUT_LEVEL_INVERT) inv_sh <= reg_wdata[0];
            if (reg_addr == ADDR_RX_NOISE_FILTER_ENABLE) nf_sh <= reg_wdata[0];
            if (reg_addr == ADDR_INPUT_ROUTE_SELECT) route_sh <= reg_wdata[1:0];
        end
    end

    // Steady sampling run; a gap or filter change restarts it, so no stale stage counts
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run <= 3'h0;
        end else if (!mck_en || (reg_wr && reg_addr == ADDR_RX_NOISE_FILTER_ENABLE)) begin
            run <= 3'h0;
        end else if (run != 3'h7) begin
            run <= run + 3'h1;
        end
    end

    AST_START: assert property (reg_wr && reg_addr == ADDR_CHANNEL_START |=>
        (chan_enabled_flag & $past(reg_wdata[1:0])) == $past(reg_wdata[1:0])
        && chan_start_pulse == $past(reg_wdata[1:0])) else $error("start write missed");
    AST_STOP: assert property (reg_wr && reg_addr == ADDR_CHANNEL_STOP |=>
        (chan_enabled_flag & $past(reg_wdata[1:0])) == 2'h0
        && chan_halt_pulse == $past(reg_wdata[1:0])) else $error("stop write missed");
    AST_HOLD: assert property (reg_wr && reg_addr == ADDR_CHANNEL_STOP && !eng_data_update
        && !eng_clock_update |-> ##2 $stable(serial_clock_pin) && $stable(serial_data_out_pin))
        else $error("pins moved on stop");
    AST_TRIG_READ: assert property (reg_rd && reg_addr == ADDR_CHANNEL_STOP |=>
        reg_rdata == 8'h00) else $error("stop register read not zero");
    AST_DATA_SW: assert property (reg_wr && reg_addr == ADDR_SERIAL_DATA_OUT_BUFFER
        && !soe_sh |-> ##2 serial_data_out_pin == ($past(reg_wdata[0], 2)
        ^ ($past(soe_sh) & $past(inv_sh)))) else $error("software data level wrong");
    AST_DATA_LOCK: assert property (reg_wr && reg_addr == ADDR_SERIAL_DATA_OUT_BUFFER
        && soe_sh && !eng_data_update |-> ##2 $stable(serial_data_out_pin))
        else $error("locked data buffer changed");
    AST_DATA_ENG: assert property (eng_data_update && soe_sh |-> ##2
        serial_data_out_pin == ($past(eng_data_value, 2) ^ ($past(soe_sh) & $past(inv_sh))))
        else $error("engine data level wrong");
    AST_CLK_SW: assert property (reg_wr && reg_addr == ADDR_SERIAL_CLOCK_OUT_BUFFER
        && !chan_enabled_flag[0] |-> ##2 serial_clock_pin == $past(reg_wdata[0], 2))
        else $error("software clock level wrong");
    AST_ROUTE_IRQ: assert property (1'b1 |=> ext_irq_input ==
        ($past(route_sh[0]) ? rx_level : $past(ext_irq_pin))) else $error("irq route wrong");
    AST_ROUTE_TMR: assert property (1'b1 |=> timer_ch1_input ==
        ($past(route_sh[1]) ? rx_level : $past(timer_ch1_pin))) else $error("timer route wrong");
    AST_RX_PLAIN: assert property (run == 3'h7 && !nf_sh |->
        rx_level == $past(uart_rx_pin, 4)) else $error("unfiltered receive level wrong");
    AST_RX_FILTER: assert property (run == 3'h7 && nf_sh && $changed(rx_level) |->
        rx_level == $past(uart_rx_pin, 4) && rx_level == $past(uart_rx_pin, 5))
        else $error("filter passed an unstable level");

    COV_START: cover property (reg_wr && reg_addr == ADDR_CHANNEL_START);
    COV_ENG_INV: cover property (eng_data_update && soe_sh && inv_sh);
    COV_FILTER: cover property (run == 3'h7 && nf_sh && $changed(rx_level));
endmodule

bind scoc_top scoc_top_chk i_scoc_top_chk (.*);

//--- test/tb_scoc_top.sv
// Purpose: Self-checking bench for the serial channel output control block.
// Assumes: Pins settle within three cycles of a register or engine update.
// Notes: Engine strobes and routed pins come from here; the peer drives receive.
module tb_scoc_top
    import scoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, rst, reg_wr, reg_rd, mck_en, rx_level, uart_rx_pin;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic eng_data_update, eng_data_value, eng_clock_update, eng_clock_value;
    logic [NUM_CH-1:0] chan_enabled_flag, chan_start_pulse, chan_halt_pulse;
    logic ext_irq_pin, timer_ch1_pin, serial_data_out_pin, serial_clock_pin;
    logic ext_irq_input, timer_ch1_input;
    logic [2:0] seen;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    localparam logic [19:0] RA [10] = '{20'hf0070, 20'hf0073, 20'hf0120, 20'hf0122,
        20'hf0124, 20'hf0128, 20'hf0129, 20'hf012a, 20'hf0134, 20'hf0130};
    localparam logic [7:0] RV [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03,
        8'h00, 8'h00, 8'h00};

    scoc_top i_scoc_top (.*);
    scoc_peer i_scoc_peer (.sys_clk, .uart_rx_pin);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe dropped and a spare edge left, so no strobe is set twice in one step
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic rdc(input logic [19:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        chk(reg_rdata, exp);
        @(posedge sys_clk);
        #1;
    endtask

    task automatic eng(input logic clk_sel, input logic v);
        eng_data_update = !clk_sel;
        eng_clock_update = clk_sel;
        eng_data_value = v;
        eng_clock_value = v;
        @(posedge sys_clk);
        #1 eng_data_update = 1'b0;
        eng_clock_update = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic pins(input logic [1:0] exp);
        repeat (3) @(posedge sys_clk);
        #1 chk({6'h0, serial_clock_pin, serial_data_out_pin}, {6'h0, exp});
    endtask

    // Low burst of n edges; notes which of receive, irq and timer lines went low
    task automatic rx_try(input int n, input logic [2:0] exp);
        seen = 3'h0;
        i_scoc_peer.send_level(1'b0, n);
        repeat (10) begin
            @(posedge sys_clk);
            #1 seen = seen | {!timer_ch1_input, !ext_irq_input, !rx_level};
        end
        chk({5'h0, seen}, {5'h0, exp});
    endtask

    initial begin
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mck_en = 1'b1;
        eng_data_update = 1'b0;
        eng_data_value = 1'b0;
        eng_clock_update = 1'b0;
        eng_clock_value = 1'b0;
        ext_irq_pin = 1'b1;
        timer_ch1_pin = 1'b1;
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 10; i++) rdc(RA[i], RV[i]);
        pins(2'b11);
        // Triggers on both channels; the status register is read-only
        wr(ADDR_CHANNEL_START, 8'h02);
        rdc(ADDR_CHANNEL_ENABLE_STATUS, 8'h02);
        wr(ADDR_CHANNEL_START, 8'h01);
        rdc(ADDR_CHANNEL_ENABLE_STATUS, 8'h03);
        wr(ADDR_CHANNEL_STOP, 8'h02);
        rdc(ADDR_CHANNEL_STOP, 8'h00);
        wr(ADDR_CHANNEL_ENABLE_STATUS, 8'h00);
        rdc(ADDR_CHANNEL_ENABLE_STATUS, 8'h01);
        // Clock buffer is the engine's while channel 0 runs
        wr(ADDR_SERIAL_CLOCK_OUT_BUFFER, 8'h02);
        rdc(ADDR_SERIAL_CLOCK_OUT_BUFFER, 8'h03);
        eng(1'b1, 1'b0);
        pins(2'b01);
        wr(ADDR_CHANNEL_STOP, 8'h01);
        rdc(ADDR_CHANNEL_ENABLE_STATUS, 8'h00);
        pins(2'b01);
        rdc(ADDR_SERIAL_CLOCK_OUT_BUFFER, 8'h02);
        eng(1'b1, 1'b1);
        pins(2'b01);
        wr(ADDR_SERIAL_CLOCK_OUT_BUFFER, 8'h03);
        pins(2'b11);
        // Data pin: software level while output is off, inversion only when on
        wr(ADDR_SERIAL_DATA_OUT_BUFFER, 8'h02);
        pins(2'b10);
        wr(ADDR_OUTPUT_LEVEL_INVERT, 8'h01);
        pins(2'b10);
        wr(ADDR_SERIAL_DATA_OUT_BUFFER, 8'h03);
        wr(ADDR_SERIAL_OUTPUT_ENABLE, 8'h01);
        pins(2'b10);
        eng(1'b0, 1'b0);
        pins(2'b11);
        wr(ADDR_SERIAL_DATA_OUT_BUFFER, 8'h03);
        rdc(ADDR_SERIAL_DATA_OUT_BUFFER, 8'h02);
        wr(ADDR_OUTPUT_LEVEL_INVERT, 8'h00);
        wr(ADDR_SERIAL_OUTPUT_ENABLE, 8'h00);
        pins(2'b10);
        eng(1'b0, 1'b1);
        pins(2'b10);
        wr(ADDR_SERIAL_DATA_OUT_BUFFER, 8'h03);
        pins(2'b11);
        // Receive routing, filter off, one-edge bursts
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_INPUT_ROUTE_SELECT, i[7:0]);
            rx_try(1, {i[1], i[0], 1'b1});
        end
        // Routed inputs ignore their own pins; plain ones follow them
        ext_irq_pin = 1'b0;
        timer_ch1_pin = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk({6'h0, timer_ch1_input, ext_irq_input}, 8'h03);
        timer_ch1_pin = 1'b1;
        wr(ADDR_INPUT_ROUTE_SELECT, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1 chk({6'h0, timer_ch1_input, ext_irq_input}, 8'h02);
        ext_irq_pin = 1'b1;
        timer_ch1_pin = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk({6'h0, timer_ch1_input, ext_irq_input}, 8'h01);
        timer_ch1_pin = 1'b1;
        // Filter on: one-edge burst dropped, two-edge burst kept
        wr(ADDR_RX_NOISE_FILTER_ENABLE, 8'h01);
        rx_try(1, 3'b000);
        rx_try(2, 3'b001);
        mck_en = 1'b0;
        rx_try(12, 3'b000);
        mck_en = 1'b1;
        tally_and_finish();
    end
endmodule
